//--- core/packer_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PACKER_REGS_SVH
`define PACKER_REGS_SVH
`define PK_OFS_LEN 8'h00
`define PK_OFS_DELIM 8'h04
`define PK_OFS_MODE 8'h08
`define PK_OFS_FORCE 8'h0c
`define PK_OFS_STAT 8'h10
`define PK_OFS_FRAMES 8'h14
`define PK_DELIM1_LSB 0
`define PK_DELIM2_LSB 8
`define PK_MATCH_BIT 0
`define PK_PROC_LSB 1
`define PK_RST_LEN 11'h000
`define PK_RST_DELIM 8'h00
`define PK_RST_MATCH 1'b1
`define PK_RST_PROC 2'h0
`define PK_RST_FORCE 16'h0000
`define PK_BUF_BYTES 1024
`define PK_FIFO_DEPTH 16
`define PK_MS_NS 1000000
`define PK_CLK_NS 10
`endif

//--- core/packer_pkg.sv
// Types shared by the serial data packer modules.
package packer_pkg;
   typedef enum logic [0:0] {
      ST_COLLECT = 1'b0,
      ST_SEND = 1'b1
   } packState_t;
   typedef enum logic [1:0] {
      PROC_NONE = 2'b00,
      PROC_PLUS1 = 2'b01,
      PROC_PLUS2 = 2'b10
   } delimProc_t;
   typedef logic [7:0] dataByte_t;
endpackage

//--- core/stream_if.sv
// Valid/ready byte stream between the input FIFO and the packer.
interface stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport source(output data, output valid, input ready);
   modport sink(input data, input valid, output ready);
endinterface

//--- core/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk, // System clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] inData, // Word offered by the source.
   input wire logic inValid, // Source offers a word.
   output logic inReady, // Room for a word, registered.
   stream_if.source out // Drain side.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   // A push is only taken while room is advertised, so full is honest.
   assign push = inValid && inReady;
   assign pop = out.valid && out.ready;
   assign out.valid = (count != '0);
   assign out.data = mem[rdPtr];
   assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // Storage has no reset; only the pointers and count define what is valid.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   // Pointers, occupancy and the registered ready flag.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         inReady <= 1'b1;
      end else begin
         if (push) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= rdPtr + 1'b1;
         end
         count <= next_count;
         inReady <= (next_count != (AW+1)'(DEPTH));
      end
   end
endmodule

//--- core/serial_data_packer.sv
// Serial byte packer: gathers bytes into frames for the network side.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`include "packer_regs.svh"
module serial_data_packer #(
   parameter int MsCycles = `PK_MS_NS / `PK_CLK_NS
) (
   input wire logic clk, // System clock, 100 MHz.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic hsel, // AHB-Lite slave select.
   input wire logic [31:0] haddr, // AHB-Lite address.
   input wire logic [1:0] htrans, // AHB-Lite transfer type.
   input wire logic hwrite, // AHB-Lite write flag.
   input wire logic [2:0] hsize, // AHB-Lite transfer size.
   input wire logic [31:0] hwdata, // AHB-Lite write data.
   input wire logic hready, // AHB-Lite bus ready.
   output logic hreadyout, // Slave ready, always high.
   output logic hresp, // Slave response, always OKAY.
   output logic [31:0] hrdata, // Read data.
   input wire packer_pkg::dataByte_t rxData, // Byte from the serial side.
   input wire logic rxValid, // Serial byte offered.
   output logic rxReady, // Input FIFO has room.
   output packer_pkg::dataByte_t txData, // Frame byte to the network.
   output logic txValid, // Frame byte valid.
   output logic txLast, // Last byte of the frame.
   input wire logic txReady // Network side takes the byte.
);
   import packer_pkg::*;
   localparam int BufBytes = `PK_BUF_BYTES;

   // ==========================================================
   // Register bus
   logic [10:0] lenLimit;
   dataByte_t delim1;
   dataByte_t delim2;
   logic matchTwo;
   delimProc_t delimProc;
   logic [15:0] forceMs;
   logic [31:0] frameTotal;
   logic wrPend;
   logic [7:0] wrAddr;
   logic addrPhase;
   logic [31:0] readMux;
   logic [10:0] count;
   packState_t state;
   // An address phase counts only while the bus is ready.
   assign addrPhase = hsel && hready && htrans[1];

   // Read mux; unmapped offsets read as zero.
   always_comb begin
      readMux = 32'h0000_0000;
      unique case (haddr[7:0])
         `PK_OFS_LEN: readMux = {21'h000000, lenLimit};
         `PK_OFS_DELIM: readMux = {16'h0000, delim2, delim1};
         `PK_OFS_MODE: readMux = {29'h00000000, delimProc, matchTwo};
         `PK_OFS_FORCE: readMux = {16'h0000, forceMs};
         `PK_OFS_STAT: readMux = {20'h00000, state, count};
         `PK_OFS_FRAMES: readMux = frameTotal;
         default: readMux = 32'h0000_0000;
      endcase
   end

   // Zero-wait slave: read data is loaded at the address phase edge.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
      end else begin
         wrPend <= addrPhase && hwrite;
         if (addrPhase) begin
            wrAddr <= haddr[7:0];
         end
         if (addrPhase && !hwrite) begin
            hrdata <= readMux;
         end
      end
   end

   // Configuration writes land in the data phase with hwdata.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lenLimit <= `PK_RST_LEN;
         delim1 <= `PK_RST_DELIM;
         delim2 <= `PK_RST_DELIM;
         matchTwo <= `PK_RST_MATCH;
         delimProc <= delimProc_t'(`PK_RST_PROC);
         forceMs <= `PK_RST_FORCE;
      end else if (wrPend) begin
         unique case (wrAddr)
            `PK_OFS_LEN: lenLimit <= hwdata[10:0];
            `PK_OFS_DELIM: begin
               delim1 <= hwdata[`PK_DELIM1_LSB +: 8];
               delim2 <= hwdata[`PK_DELIM2_LSB +: 8];
            end
            `PK_OFS_MODE: begin
               matchTwo <= hwdata[`PK_MATCH_BIT];
               delimProc <= delimProc_t'(hwdata[`PK_PROC_LSB +: 2]);
            end
            `PK_OFS_FORCE: forceMs <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Input FIFO
   stream_if #(.W(8)) popIf();
   byte_fifo #(.WIDTH(8), .DEPTH(`PK_FIFO_DEPTH)) inFifo (
      .clk(clk),
      .rst_b(rst_b),
      .inData(rxData),
      .inValid(rxValid),
      .inReady(rxReady),
      .out(popIf)
   );

   // ==========================================================
   // Collection and release decision
   dataByte_t buffer [BufBytes];
   logic [10:0] frameLen;
   logic [10:0] rdIdx;
   logic prevD1;
   logic [1:0] tailLeft;
   logic [16:0] msCount;
   logic [31:0] tickCount;
   logic popFire;
   dataByte_t popByte;
   logic noDelim;
   logic delimHit;
   logic lenHit;
   logic fullHit;
   logic tailHit;
   logic timeoutHit;
   logic releaseNow;

   // Bytes are drained only while collecting, so a frame in flight
   // stalls the FIFO and back-pressure reaches the serial side.
   assign popIf.ready = (state == ST_COLLECT);
   assign popFire = popIf.valid && popIf.ready;
   assign popByte = popIf.data;
   assign noDelim = (delim1 == 8'h00) && (delim2 == 8'h00);

   // Delimiter match on the byte being taken now.
   always_comb begin
      delimHit = 1'b0;
      if (delim1 == 8'h00) begin
         delimHit = (delim2 != 8'h00) && (popByte == delim2);
      end else if (delim2 == 8'h00) begin
         delimHit = (popByte == delim1);
      end else if (matchTwo) begin
         delimHit = prevD1 && (popByte == delim2);
      end else begin
         delimHit = (popByte == delim1) || (popByte == delim2);
      end
   end
   // Length limit zero means no length-based release at all.
   assign lenHit = (lenLimit != 11'h000) && (count + 11'h001 == lenLimit);
   assign fullHit = (count == 11'(BufBytes - 1));
   assign tailHit = (tailLeft == 2'h1);

   // Trailing bytes only apply with the first delimiter in use.
   always_comb begin
      releaseNow = 1'b0;
      if (popFire) begin
         if (noDelim || lenHit || fullHit || tailHit) begin
            releaseNow = 1'b1;
         end else if (tailLeft == 2'h0 && delimHit) begin
            releaseNow = (delim1 == 8'h00) || (delimProc == PROC_NONE);
         end
      end
   end
   // Idle timer: zero setting disables timeout release entirely.
   assign timeoutHit = (state == ST_COLLECT) && !popFire &&
      (count != 11'h000) && (forceMs != 16'h0000) &&
      (msCount >= {1'b0, forceMs});
   // Millisecond prescaler and idle counter, restarted on every byte.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tickCount <= 32'h0000_0000;
         msCount <= 17'h00000;
      end else if (popFire || state == ST_SEND) begin
         tickCount <= 32'h0000_0000;
         msCount <= 17'h00000;
      end else if (tickCount == 32'(MsCycles - 1)) begin
         tickCount <= 32'h0000_0000;
         if (msCount != 17'h1ffff) begin
            msCount <= msCount + 17'h00001;
         end
      end else begin
         tickCount <= tickCount + 32'h0000_0001;
      end
   end
   // Every taken byte, delimiters and trailers included, is stored.
   always_ff @(posedge clk) begin
      if (popFire) begin
         buffer[count[9:0]] <= popByte;
      end
   end
   // Delimiter tracking and trailing-byte countdown.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prevD1 <= 1'b0;
         tailLeft <= 2'h0;
      end else if (releaseNow || timeoutHit) begin
         prevD1 <= 1'b0;
         tailLeft <= 2'h0;
      end else if (popFire) begin
         prevD1 <= (delim1 != 8'h00) && (popByte == delim1);
         if (tailLeft != 2'h0) begin
            tailLeft <= tailLeft - 2'h1;
         end else if (delimHit && delim1 != 8'h00) begin
            tailLeft <= delimProc;
         end
      end
   end

   // Frame state: collect bytes, then send the buffer out and clear.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_COLLECT;
         count <= 11'h000;
         frameLen <= 11'h000;
      end else begin
         unique case (state)
            ST_COLLECT: begin
               if (releaseNow) begin
                  frameLen <= count + 11'h001;
                  state <= ST_SEND;
               end else if (timeoutHit) begin
                  frameLen <= count;
                  state <= ST_SEND;
               end else if (popFire) begin
                  count <= count + 11'h001;
               end
            end
            ST_SEND: begin
               if (txValid && txReady && txLast) begin
                  count <= 11'h000;
                  state <= ST_COLLECT;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Frame output
   // Output bytes are registered so the network side sees clean flops.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txData <= 8'h00;
         txValid <= 1'b0;
         txLast <= 1'b0;
         rdIdx <= 11'h000;
         frameTotal <= 32'h0000_0000;
      end else if (state == ST_SEND) begin
         if (!txValid || txReady) begin
            if (txValid && txLast) begin
               txValid <= 1'b0;
               txLast <= 1'b0;
               rdIdx <= 11'h000;
               frameTotal <= frameTotal + 32'h0000_0001;
            end else begin
               txData <= buffer[rdIdx[9:0]];
               txValid <= 1'b1;
               txLast <= (rdIdx + 11'h001 == frameLen);
               rdIdx <= rdIdx + 11'h001;
            end
         end
      end else begin
         txValid <= 1'b0;
         txLast <= 1'b0;
         rdIdx <= 11'h000;
      end
   end

   // ==========================================================
   // Checks
   property p_len_release;
      @(posedge clk) disable iff (!rst_b)
      popFire && lenLimit != 11'h000 && count + 11'h001 == lenLimit
         |=> state == ST_SEND && frameLen == $past(count) + 11'h001;
   endproperty
   a_len_release: assert property (p_len_release)
      else $error("Length limit reached without release.");
   property p_no_len;
      @(posedge clk) disable iff (!rst_b)
      popFire && lenLimit == 11'h000 && !noDelim && !delimHit &&
         tailLeft == 2'h0 && count < 11'h3fe |-> !releaseNow;
   endproperty
   a_no_len: assert property (p_no_len)
      else $error("Release without cause while length is zero.");
   property p_pass_through;
      @(posedge clk) disable iff (!rst_b)
      state == ST_COLLECT && popFire && noDelim
         |=> state == ST_SEND ##1 txValid && txLast;
   endproperty
   a_pass_through: assert property (p_pass_through)
      else $error("Byte held although no delimiter is set.");
   property p_hold;
      @(posedge clk) disable iff (!rst_b)
      state == ST_COLLECT && popFire && !releaseNow && !timeoutHit
         |=> state == ST_COLLECT && count == $past(count) + 11'h001;
   endproperty
   a_hold: assert property (p_hold)
      else $error("Byte not kept while waiting for delimiter.");
   property p_full;
      @(posedge clk) disable iff (!rst_b)
      popFire && count == 11'h3ff |=> state == ST_SEND && frameLen == 11'h400;
   endproperty
   a_full: assert property (p_full)
      else $error("Full buffer not released.");
   property p_one_byte;
      @(posedge clk) disable iff (!rst_b)
      popFire && !matchTwo && delim1 != 8'h00 && delim2 != 8'h00 &&
         (popByte == delim1 || popByte == delim2) |-> delimHit;
   endproperty
   a_one_byte: assert property (p_one_byte)
      else $error("Single delimiter not matched in one-byte mode.");
   property p_two_byte;
      @(posedge clk) disable iff (!rst_b)
      popFire && matchTwo && delim1 != 8'h00 && delim2 != 8'h00 &&
         (count == 11'h000 || buffer[count[9:0] - 10'h001] != delim1)
         |-> !delimHit;
   endproperty
   a_two_byte: assert property (p_two_byte)
      else $error("Two-byte match without preceding first delimiter.");
   property p_tail_wait;
      @(posedge clk) disable iff (!rst_b)
      popFire && delimHit && tailLeft == 2'h0 && delim1 != 8'h00 &&
         delimProc != PROC_NONE && !lenHit && !fullHit |-> !releaseNow;
   endproperty
   a_tail_wait: assert property (p_tail_wait)
      else $error("Released before trailing bytes arrived.");
   property p_no_timeout;
      @(posedge clk) disable iff (!rst_b)
      state == ST_COLLECT && !popFire && forceMs == 16'h0000
         |=> state == ST_COLLECT;
   endproperty
   a_no_timeout: assert property (p_no_timeout)
      else $error("Timeout release while timeout is disabled.");
   property p_cleared;
      @(posedge clk) disable iff (!rst_b)
      $past(state) == ST_SEND && state == ST_COLLECT
         |-> count == 11'h000 && !txValid;
   endproperty
   a_cleared: assert property (p_cleared)
      else $error("Buffer not cleared after a frame.");
endmodule

//--- test/serial_host.sv
// Host equipment model that offers serial bytes on a valid/ready link.
module serial_host (
   input wire logic clk, // System clock.
   output packer_pkg::dataByte_t rxData, // Byte toward the packer.
   output logic rxValid, // Byte offered.
   input wire logic rxReady // Packer input has room.
);
   timeunit 1ns;
   timeprecision 1ps;
   import packer_pkg::*;

   // ==========================================================
   // Byte source
   // Idle until the first transfer asks for the line.
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
   end

   // Each byte is held until taken, and some follow back to back.
   // A released line shows the inverted byte, so stale data cannot
   // pass for a fresh one.
   task automatic sendBytes(input dataByte_t bytes[$]);
      int gap;
      for (int i = 0; i < bytes.size(); i++) begin
         rxValid <= 1'b1;
         rxData <= bytes[i];
         do @(posedge clk); while (rxReady !== 1'b1);
         gap = i % 3;
         if (gap != 0 || i == bytes.size() - 1) begin
            rxValid <= 1'b0;
            rxData <= ~bytes[i];
            repeat (gap + (gap == 0)) @(posedge clk);
         end
      end
   endtask
endmodule

//--- test/serial_data_packer_tb.sv
// Self-checking testbench for the serial data packer.
`include "packer_regs.svh"
module serial_data_packer_tb import packer_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst_b;
   logic hsel;
   logic hwrite;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   dataByte_t rxData;
   logic rxValid;
   logic rxReady;
   dataByte_t txData;
   logic txValid;
   logic txLast;
   logic txReady;
   logic [8:0] expQ[$];
   dataByte_t bq[$];
   logic [31:0] rd;
   int numErrors = 0;
   int nCompared = 0;
   int nFrames = 0;
   int seed = 57443;

   // ==========================================================
   // Clock, design and host model
   always #5 clk = ~clk;

   // One millisecond is shortened to ten cycles to keep runs short.
   serial_data_packer #(.MsCycles(10)) dut (
      .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rxData(rxData),
      .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
      .txValid(txValid), .txLast(txLast), .txReady(txReady)
   );

   serial_host host (
      .clk(clk), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady)
   );

   // ==========================================================
   // Checking and closing
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         numErrors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (numErrors == 0 && nCompared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Frame bytes are compared in order; a byte with no note is wrong.
   // The network side stalls at random to stretch each frame.
   always @(posedge clk) begin
      if (rst_b === 1'b1 && txValid === 1'b1 && txReady === 1'b1) begin
         if (expQ.size() == 0) begin
            check("stray byte", {23'h0, txLast, txData}, 32'hffffffff);
         end else begin
            check("frame byte", {23'h0, txLast, txData}, {23'h0, expQ.pop_front()});
         end
      end
      txReady <= ($random(seed) & 3) != 0;
   end

   // A hang is cut short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      numErrors++;
      conclude();
   end

   // ==========================================================
   // Bus and stimulus helpers
   // Single AHB-Lite transfer; read data is taken at the data edge.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Bit four is forced so random bytes never hit a delimiter.
   function automatic dataByte_t rndByte();
      return dataByte_t'($random(seed)) | 8'h10;
   endfunction

   task automatic noteFrame(input dataByte_t b[$]);
      foreach (b[i]) expQ.push_back({i == b.size() - 1, b[i]});
      nFrames++;
   endtask

   task automatic frame(input dataByte_t b[$]);
      noteFrame(b);
      host.sendBytes(b);
   endtask

   task automatic drain();
      for (int i = 0; i < 20000 && expQ.size() != 0; i++) @(posedge clk);
      // Bytes still owed when the wait runs out count as a mismatch.
      check("pending bytes", 32'(expQ.size()), 32'h0);
      repeat (4) @(posedge clk);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      // Counters are read-only, so this write must not stick.
      bus(1'b1, `PK_OFS_FRAMES, 32'h000000ff);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0);
         check("reset value", rd, (i * 4 == `PK_OFS_MODE) ? 32'h1 : 32'h0);
      end
      bus(1'b1, 8'h20, 32'h12345678);
      bus(1'b0, 8'h20, 32'h0);
      check("unmapped read", rd, 32'h0);
      // With no delimiter every byte leaves as its own frame.
      for (int i = 0; i < 3; i++) begin
         bq = {rndByte()};
         frame(bq);
      end
      drain();
      bus(1'b1, `PK_OFS_DELIM, 32'h0000000d);
      bus(1'b1, `PK_OFS_LEN, 32'd4);
      bq = {rndByte(), rndByte(), rndByte(), rndByte()};
      frame(bq);
      drain();
      bus(1'b1, `PK_OFS_LEN, 32'd0);
      bq = {rndByte(), rndByte(), 8'h0d};
      frame(bq);
      drain();
      // A full buffer releases without any delimiter.
      bq.delete();
      repeat (1024) bq.push_back(rndByte());
      frame(bq);
      drain();
      // Without a timeout the bytes wait for the delimiter.
      bq = {rndByte(), rndByte(), 8'h0d};
      noteFrame(bq);
      host.sendBytes(bq[0:1]);
      repeat (300) @(posedge clk);
      bus(1'b0, `PK_OFS_STAT, 32'h0);
      check("held count", {21'h0, rd[10:0]}, 32'd2);
      host.sendBytes(bq[2:2]);
      drain();
      bus(1'b1, `PK_OFS_DELIM, 32'h00000a0d);
      bq = {8'h0d, rndByte(), 8'h0d, 8'h0a};
      frame(bq);
      drain();
      bus(1'b1, `PK_OFS_MODE, 32'h0);
      bq = {rndByte(), 8'h0a};
      frame(bq);
      drain();
      // A lone second delimiter acts as a single-character marker.
      bus(1'b1, `PK_OFS_DELIM, 32'h00000a00);
      bq = {rndByte(), 8'h0a};
      frame(bq);
      drain();
      bus(1'b1, `PK_OFS_DELIM, 32'h00000a0d);
      for (int p = 1; p <= 2; p++) begin
         bus(1'b1, `PK_OFS_MODE, 32'(p * 2 + 1));
         bq = {rndByte(), 8'h0d, 8'h0a, rndByte()};
         if (p == 2) begin
            bq.push_back(rndByte());
         end
         frame(bq);
         drain();
      end
      // Two ms is far above the byte spacing used here.
      bus(1'b1, `PK_OFS_MODE, 32'h1);
      bus(1'b1, `PK_OFS_FORCE, 32'd2);
      bq = {rndByte(), rndByte()};
      frame(bq);
      drain();
      bus(1'b0, `PK_OFS_STAT, 32'h0);
      check("emptied count", {21'h0, rd[10:0]}, 32'h0);
      bus(1'b0, `PK_OFS_FRAMES, 32'h0);
      check("frame count", rd, 32'(nFrames));
      conclude();
   end
endmodule
